// file: common/timer_pair_pkg.sv
// Purpose: constants for the dual reload timer pair
// Assumes: apb slave, 32-bit data, one word per register
// Notes:   control offset 0xFF20; other offsets chosen locally
package timer_pair_pkg;
   localparam logic [15:0] CTRL_OFFSET   = 16'hFF20;
   localparam logic [15:0] TIMER_A_OFF   = 16'hFF30;
   localparam logic [15:0] TIMER_B_OFF   = 16'hFF34;
   localparam logic [15:0] RELOAD_A_OFF  = 16'hFF38;
   localparam logic [15:0] RELOAD_B_OFF  = 16'hFF3C;
   localparam logic [15:0] IRQ_STAT_OFF  = 16'hFF40;
   localparam logic [15:0] IRQ_MASK_OFF  = 16'hFF44;
   localparam logic [15:0] CTRL_RESET    = 16'h0000;
   localparam logic [15:0] TIMER_RESET   = 16'h0000;
   localparam logic [15:0] CTRL_WMASK    = 16'h4F4F;
   localparam int          RUN_BIT       = 6;
   localparam int          MODE_BIT      = 3;
   localparam int          SEL_LSB       = 0;
   localparam int          B_SHIFT       = 8;
   localparam int          PRESC_BASE    = 3;
   localparam int          PRESC_WIDTH   = 10;
   localparam logic [2:0]  SRC_UPSTREAM  = 3'h0;
   localparam logic [2:0]  SRC_RISE      = 3'h1;
   localparam logic [2:0]  SRC_FALL      = 3'h2;
   localparam logic [2:0]  SRC_BOTH      = 3'h3;
endpackage

// file: core/dual_reload_timer_pair.sv
// Purpose: two 16-bit up timers with reload, apb registers, one irq
// Assumes: ext_count_pin_i and upstream_tick_i are asynchronous
// Notes:   timer_b services its events one cycle after timer_a
`timescale 1ns/1ps
module dual_reload_timer_pair
(
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [15:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        ext_count_pin_i,
   input  wire logic        upstream_tick_i,
   output logic             timer_a_overflow_o,
   output logic             timer_b_overflow_o,
   output logic             irq_o
);
   localparam int PRESC_W_L = timer_pair_pkg::PRESC_WIDTH;

   // reset and input synchronisers
   logic        rst_meta;
   logic        rst_n;
   logic [1:0]  pin_sync;
   logic        pin_prev;
   logic [1:0]  up_sync;
   logic        up_prev;

   // prescaler and count events
   logic [PRESC_W_L-1:0] presc;
   logic [7:0]  presc_strobe;
   logic [1:0]  tick;
   logic        tick_b_delay;
   logic        rise;
   logic        fall;
   logic        up_evt;

   // software visible state
   logic [15:0] timer_pair_control;
   logic [15:0] timer_a;
   logic [15:0] timer_b;
   logic [15:0] next_timer_a;
   logic [15:0] next_timer_b;
   logic [15:0] reload_a;
   logic [15:0] reload_b;
   logic [1:0]  ovf_flag;
   logic [1:0]  ovf_mask;
   logic [2:0]  sel_a;
   logic [2:0]  sel_b;

   // bus decode
   logic        hit;
   logic        wr_en;
   logic        rd_en;
   logic        wr_ctrl;
   logic        wr_tmr_a;
   logic        wr_tmr_b;
   logic        wr_rel_a;
   logic        wr_rel_b;
   logic        wr_stat;
   logic        wr_mask;
   logic [31:0] read_word;

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // pin synchroniser and edge history
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_sync <= 2'h0;
         pin_prev <= 1'b0;
      end
      else
      begin
         pin_sync <= {pin_sync[0], ext_count_pin_i};
         pin_prev <= pin_sync[1];
      end
   end

   // upstream tick synchroniser and edge history
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         up_sync  <= 2'h0;
         up_prev  <= 1'b0;
      end
      else
      begin
         up_sync  <= {up_sync[0], upstream_tick_i};
         up_prev  <= up_sync[1];
      end
   end

   assign rise   = pin_sync[1] & ~pin_prev;
   assign fall   = ~pin_sync[1] & pin_prev;
   assign up_evt = up_sync[1] & ~up_prev;

   // free running prescaler shared by both timers
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
         presc <= '0;
      else
         presc <= presc + 1'b1;
   end

   // one strobe per prescale code, high when bit sel+2 is set and the bits below it are clear
   for (genvar k = 0; k < 8; k++)
   begin
      assign presc_strobe[k] = presc[k + timer_pair_pkg::PRESC_BASE - 1] &&
                               (presc[k + timer_pair_pkg::PRESC_BASE - 2:0] == '0);
   end

   assign sel_a = timer_pair_control[timer_pair_pkg::SEL_LSB +: 3];
   assign sel_b = timer_pair_control[timer_pair_pkg::B_SHIFT + timer_pair_pkg::SEL_LSB +: 3];

   function automatic logic tick_for(input logic run, input logic mode,
                                     input logic [2:0] sel, input logic is_b,
                                     input logic [7:0] ps,
                                     input logic re, input logic fe,
                                     input logic ue);
      logic t;
      t = 1'b0;
      if (!run)
         t = 1'b0;
      else if (!mode)
         t = ps[sel];
      else
      begin
         case (sel)
            timer_pair_pkg::SRC_UPSTREAM: t = ue;
            timer_pair_pkg::SRC_RISE:     t = !is_b && re;
            timer_pair_pkg::SRC_FALL:     t = !is_b && fe;
            timer_pair_pkg::SRC_BOTH:     t = !is_b && (re || fe);
            default:                      t = 1'b0;
         endcase
      end
      return t;
   endfunction

   assign tick[0] = tick_for(timer_pair_control[timer_pair_pkg::RUN_BIT],
                             timer_pair_control[timer_pair_pkg::MODE_BIT],
                             sel_a, 1'b0, presc_strobe, rise, fall, up_evt);
   assign tick[1] = tick_for(timer_pair_control[timer_pair_pkg::B_SHIFT + timer_pair_pkg::RUN_BIT],
                             timer_pair_control[timer_pair_pkg::B_SHIFT + timer_pair_pkg::MODE_BIT],
                             sel_b, 1'b1, presc_strobe, rise, fall, up_evt);

   // timer_b event delayed one cycle behind timer_a
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
         tick_b_delay <= 1'b0;
      else
         tick_b_delay <= tick[1];
   end

   assign hit   = (paddr_i == timer_pair_pkg::CTRL_OFFSET)  ||
                  (paddr_i == timer_pair_pkg::TIMER_A_OFF)  ||
                  (paddr_i == timer_pair_pkg::TIMER_B_OFF)  ||
                  (paddr_i == timer_pair_pkg::RELOAD_A_OFF) ||
                  (paddr_i == timer_pair_pkg::RELOAD_B_OFF) ||
                  (paddr_i == timer_pair_pkg::IRQ_STAT_OFF) ||
                  (paddr_i == timer_pair_pkg::IRQ_MASK_OFF);
   assign wr_en     = psel_i & penable_i & pwrite_i & hit;
   assign rd_en     = psel_i & ~pwrite_i;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit;

   // register write strobes
   assign wr_ctrl  = wr_en & (paddr_i == timer_pair_pkg::CTRL_OFFSET);
   assign wr_tmr_a = wr_en & (paddr_i == timer_pair_pkg::TIMER_A_OFF);
   assign wr_tmr_b = wr_en & (paddr_i == timer_pair_pkg::TIMER_B_OFF);
   assign wr_rel_a = wr_en & (paddr_i == timer_pair_pkg::RELOAD_A_OFF);
   assign wr_rel_b = wr_en & (paddr_i == timer_pair_pkg::RELOAD_B_OFF);
   assign wr_stat  = wr_en & (paddr_i == timer_pair_pkg::IRQ_STAT_OFF);
   assign wr_mask  = wr_en & (paddr_i == timer_pair_pkg::IRQ_MASK_OFF);

   // control register
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
         timer_pair_control <= timer_pair_pkg::CTRL_RESET;
      else if (wr_ctrl)
         timer_pair_control <= pwdata_i[15:0] & timer_pair_pkg::CTRL_WMASK;
   end

   // reload registers, sampled at the moment of reload
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
         reload_a <= timer_pair_pkg::TIMER_RESET;
      else if (wr_rel_a)
         reload_a <= pwdata_i[15:0];
   end

   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
         reload_b <= timer_pair_pkg::TIMER_RESET;
      else if (wr_rel_b)
         reload_b <= pwdata_i[15:0];
   end

   // overflow interrupt mask
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
         ovf_mask <= 2'h0;
      else if (wr_mask)
         ovf_mask <= pwdata_i[1:0];
   end

   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
         timer_a <= timer_pair_pkg::TIMER_RESET;
      else if (wr_tmr_a)
         timer_a <= pwdata_i[15:0];
      else if (tick[0])
         timer_a <= next_timer_a;
   end

   always_comb
   begin
      next_timer_a = timer_a + 16'h0001;
      if (timer_a == 16'hFFFF)
         next_timer_a = reload_a;
   end

   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
         timer_b <= timer_pair_pkg::TIMER_RESET;
      else if (wr_tmr_b)
         timer_b <= pwdata_i[15:0];
      else if (tick_b_delay)
         timer_b <= next_timer_b;
   end

   always_comb
   begin
      next_timer_b = timer_b + 16'h0001;
      if (timer_b == 16'hFFFF)
         next_timer_b = reload_b;
   end

   assign timer_a_overflow_o = tick[0] & (timer_a == 16'hFFFF) & ~wr_tmr_a;
   assign timer_b_overflow_o = tick_b_delay & (timer_b == 16'hFFFF) & ~wr_tmr_b;

   // sticky flags, set wins over write-one-to-clear
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
         ovf_flag <= 2'h0;
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if ((i == 0) ? timer_a_overflow_o : timer_b_overflow_o)
               ovf_flag[i] <= 1'b1;
            else if (wr_stat && pwdata_i[i])
               ovf_flag[i] <= 1'b0;
         end
      end
   end

   assign irq_o = |(ovf_flag & ovf_mask);

   // read mux, upper half reads zero
   always_comb
   begin
      case (paddr_i)
         timer_pair_pkg::CTRL_OFFSET:  read_word = {16'h0000, timer_pair_control};
         timer_pair_pkg::TIMER_A_OFF:  read_word = {16'h0000, timer_a};
         timer_pair_pkg::TIMER_B_OFF:  read_word = {16'h0000, timer_b};
         timer_pair_pkg::RELOAD_A_OFF: read_word = {16'h0000, reload_a};
         timer_pair_pkg::RELOAD_B_OFF: read_word = {16'h0000, reload_b};
         timer_pair_pkg::IRQ_STAT_OFF: read_word = {30'h0, ovf_flag};
         timer_pair_pkg::IRQ_MASK_OFF: read_word = {30'h0, ovf_mask};
         default:                      read_word = 32'h0000_0000;
      endcase
   end

   // read data captured in the setup cycle
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
         prdata_o <= 32'h0000_0000;
      else if (rd_en && !penable_i)
         prdata_o <= read_word;
   end
endmodule

// file: tb/count_source.sv
// Purpose: far-side count source, drives the pin and the upstream tick
// Assumes: started by the bench, one clock
// Notes:   both outputs toggle together, ten cycles a level, idle low
`timescale 1ns/1ps
module count_source
(
   input  wire logic       clock_i,
   input  wire logic       start_i,
   input  wire logic [3:0] pulses_i,
   output logic            pin_o,
   output logic            tick_o,
   output logic            busy_o
);
   logic [4:0] left  = 5'h00;
   logic [3:0] phase = 4'h0;
   always @(posedge clock_i)
   begin
      if (start_i)
         left <= {pulses_i, 1'b0};
      else if (left != 5'h00 && phase == 4'h9)
         left <= left - 5'h01;
      phase <= (start_i || phase == 4'h9) ? 4'h0 : phase + 4'h1;
   end
   assign pin_o  = left != 5'h00 && !left[0];
   assign tick_o = pin_o;
   assign busy_o = left != 5'h00;
endmodule

// file: tb/timer_pair_assertions.sv
// Purpose: port checks for the timer pair
// Assumes: zero wait state apb slave
// Notes:   bound to the top module
`timescale 1ns/1ps
module timer_pair_assertions
(
   input wire logic        clock_i,
   input wire logic        rst_n_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        timer_a_overflow_o,
   input wire logic        timer_b_overflow_o,
   input wire logic        irq_o
);
   wire mapped = paddr_i == 16'hFF20
      || (paddr_i >= 16'hFF30 && paddr_i <= 16'hFF44 && paddr_i[1:0] == 2'h0);
   wire wr     = psel_i && penable_i && pwrite_i;
   wire ovf    = timer_a_overflow_o || timer_b_overflow_o;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_access;
      psel_i && penable_i;
   endsequence
   a_ready_high: assert property (pready_o)
      else $error("pready low");
   a_bad_addr_err: assert property (s_access ##0 !mapped |-> pslverr_o)
      else $error("no error on unmapped access");
   a_good_addr_ok: assert property (s_access ##0 mapped |-> !pslverr_o)
      else $error("error on mapped access");
   a_hole_reads_zero: assert property (s_access ##0 !mapped && !pwrite_i |-> prdata_o == 0)
      else $error("unmapped read not zero");
   a_ovf_a_gap: assert property (timer_a_overflow_o |=> !timer_a_overflow_o [*7])
      else $error("timer a overflows too close");
   a_ovf_b_gap: assert property (timer_b_overflow_o |=> !timer_b_overflow_o [*7])
      else $error("timer b overflows too close");
   a_irq_rise_cause: assert property ($rose(irq_o) |-> $past(ovf || wr))
      else $error("irq rose without cause");
   a_irq_sticky: assert property ($fell(irq_o) |-> $past(wr))
      else $error("irq fell without write");
endmodule
bind dual_reload_timer_pair timer_pair_assertions chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
   .timer_a_overflow_o(timer_a_overflow_o), .timer_b_overflow_o(timer_b_overflow_o));

// file: tb/dual_reload_timer_pair_test.sv
// Purpose: register level test of the timer pair
// Assumes: zero wait state apb slave
// Notes:   count source model drives pin and upstream tick
`timescale 1ns/1ps
module dual_reload_timer_pair_test;
   logic        clock_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0, start = 0;
   logic [15:0] paddr   = 0;
   logic [31:0] pwdata  = 0, rd;
   wire  [31:0] prdata_o;
   wire         pready_o, pslverr_o, pin, tick, busy, ova, ovb, irq_o;
   int          num_errors = 0, compares = 0, cyc = 0, t0, t1;
   dual_reload_timer_pair dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_count_pin_i(pin),
      .upstream_tick_i(tick), .timer_a_overflow_o(ova), .timer_b_overflow_o(ovb), .irq_o(irq_o));
   count_source src (.clock_i(clock_i), .start_i(start), .pulses_i(4'h5), .pin_o(pin),
      .tick_o(tick), .busy_o(busy));
   always #5 clock_i = ~clock_i;
   always @(posedge clock_i) cyc <= cyc + 1;
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      do @(posedge clock_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_i);
   endtask
   task check(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task rdchk(input string n, input logic [15:0] a, input logic [31:0] e);
      apb(1'b0, a, 0);
      check(n, e, rd);
   endtask
   task wait_ovf(input logic b, output int t);
      do @(negedge clock_i); while ((b ? ovb : ova) !== 1'b1);
      t = cyc;
      @(posedge clock_i);
   endtask
   task finish_test;
      if (num_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #100000;
      num_errors++;
      finish_test;
   end
   initial
   begin
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      rdchk("ctrl", 16'hFF20, 0);
      rdchk("hole", 16'hFF24, 0);
      apb(1, 16'hFF20, 32'hFFFF);
      rdchk("ctrl", 16'hFF20, 32'h4F4F);
      repeat (40) @(posedge clock_i);
      rdchk("resv", 16'hFF30, 0);
      for (int c = 0; c < 4; c++)
      begin
         apb(1, 16'hFF20, 0);
         apb(1, 16'hFF30, 0);
         apb(1, 16'hFF34, 0);
         apb(1, 16'hFF20, 32'h4848 | c * 32'h0101);
         start <= 1'b1;
         @(posedge clock_i);
         start <= 1'b0;
         repeat (2) @(posedge clock_i);
         while (busy === 1'b1) @(posedge clock_i);
         repeat (12) @(posedge clock_i);
         rdchk("cnt a", 16'hFF30, (c == 3) ? 10 : 5);
         rdchk("cnt b", 16'hFF34, (c == 0) ? 5 : 0);
      end
      apb(1, 16'hFF38, 32'hFFFF);
      apb(1, 16'hFF3C, 32'hFFFF);
      for (int s = 0; s < 3; s++)
      begin
         apb(1, 16'hFF30, 32'hFFFF);
         apb(1, 16'hFF20, 32'h0040 | s);
         wait_ovf(0, t0);
         wait_ovf(0, t1);
         check("period", 8 << s, t1 - t0);
      end
      apb(1, 16'hFF34, 32'hFFFF);
      apb(1, 16'hFF20, 32'h4040);
      wait_ovf(0, t0);
      wait_ovf(1, t1);
      check("b lag", 1, t1 - t0);
      apb(1, 16'hFF38, 32'hFFF0);
      apb(1, 16'hFF20, 32'h0042);
      wait_ovf(0, t0);
      rdchk("reload", 16'hFF30, 32'hFFF0);
      rdchk("rel reg", 16'hFF38, 32'hFFF0);
      check("irq off", 0, irq_o);
      apb(1, 16'hFF44, 1);
      check("irq on", 1, irq_o);
      apb(1, 16'hFF20, 0);
      apb(1, 16'hFF40, 3);
      rdchk("stat", 16'hFF40, 0);
      check("irq clr", 0, irq_o);
      apb(1, 16'hFF30, 32'h1234);
      repeat (50) @(posedge clock_i);
      rdchk("stopped", 16'hFF30, 32'h1234);
      finish_test;
   end
endmodule
